// ==== hw/vfc_regs.sv ====
// Control and status bank of the video capture front end
// Assumes a serial engine presents byte accesses synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "vfc_defines.svh"

module vfc_regs
	import vfc_pkg::*;
#(
	parameter int DETECT_CYCLES = `VFC_DETECT_CYCLES,
	parameter int LINE_W        = 11
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Register port from the serial engine
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire vfc_pkg::vfc_byte_t reg_addr,
	input  wire vfc_pkg::vfc_byte_t reg_wdata,
	output var  vfc_pkg::vfc_byte_t reg_rdata,
	// Sync inputs
	input  wire logic              line_sync_pin,
	input  wire logic              sog_sync,
	input  wire logic              frame_sync_pin,
	input  wire logic              black_hold_pin,
	input  wire logic              hold_pin,
	// Timing outputs
	output var  logic              clamp_pulse,
	output var  logic              pll_hold,
	output var  logic              sep_frame_sync,
	output var  logic [11:0]       pll_divide_ratio,
	// Analog and format controls
	output var  logic              power_down_n,
	output var  logic              seek_low_power,
	output var  logic              red_clamp_mid,
	output var  logic              blue_clamp_mid,
	output var  logic [4:0]        slicer_level,
	output var  logic              dual_channel,
	output var  logic              parallel_mode,
	output var  logic              first_on_b,
	output var  logic              fmt_422,
	output var  logic              input_channel,
	output var  logic [1:0]        bandwidth_sel,
	output var  logic              ext_clock_sel
);
	import vfc_pkg::*;

	localparam logic [5:0] SEP_LAST = 6'(`VFC_SEP_DIV - 1);

	if (DETECT_CYCLES < 2 || DETECT_CYCLES > 65535 ||
	    LINE_W < 8 || LINE_W > 16) begin : g_bad_param
		$error("vfc_regs: parameter out of range");
	end

	vfc_byte_t         div_hi_r, div_lo_r, clamp_pos_r, clamp_len_r;
	vfc_byte_t         ctrl_r, slice_r, sep_thr_r, lead_r, trail_r;
	vfc_byte_t         fmt_r, tsta_r, tstb_r, stat_r, rdata_r;
	logic [11:0]       div_r;
	logic [3:0]        mon_in, mon_present, mon_high;
	logic              line_norm, sog_norm, frame_norm;
	logic              active_line_sync_flag, active_frame_sync_flag;
	logic              hold_pol, hold_pin_act;
	logic              sel_line_r, sel_line_d_r, frame_sel_r, frame_sel_d_r;
	logic              line_lead, line_trail, frame_start, lead_hit;
	logic [5:0]        tick_r;
	logic              sep_tick_r, sep_state_r;
	vfc_byte_t         sep_cnt_r, trail_cnt_r, cl_cnt_r;
	logic [LINE_W-1:0] lines_r, frame_lines_r;
	vfc_clamp_st_t     cl_st_r;
	logic              clamp_r, pll_hold_r;

	function automatic logic wr_to(input vfc_byte_t off);
		return reg_wr && (reg_addr == off);
	endfunction

	// Writable registers; status and test readback are not written here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_hi_r    <= `VFC_RST_DIV_HI;
			div_lo_r    <= `VFC_RST_DIV_LO;
			clamp_pos_r <= `VFC_RST_CLAMP_POS;
			clamp_len_r <= `VFC_RST_CLAMP_LEN;
			ctrl_r      <= `VFC_RST_CTRL;
			slice_r     <= `VFC_RST_SLICE;
			sep_thr_r   <= `VFC_RST_SEP;
			lead_r      <= `VFC_RST_LEAD;
			trail_r     <= `VFC_RST_TRAIL;
			fmt_r       <= `VFC_RST_FMT;
			tsta_r      <= `VFC_RST_TSTA;
			tstb_r      <= `VFC_RST_TSTB;
		end else begin
			if (wr_to(`VFC_OFF_DIV_HI))    div_hi_r    <= reg_wdata;
			if (wr_to(`VFC_OFF_DIV_LO))    div_lo_r    <= reg_wdata & `VFC_MASK_DIV_LO;
			if (wr_to(`VFC_OFF_CLAMP_POS)) clamp_pos_r <= reg_wdata;
			if (wr_to(`VFC_OFF_CLAMP_LEN)) clamp_len_r <= reg_wdata;
			if (wr_to(`VFC_OFF_CTRL))      ctrl_r      <= reg_wdata & `VFC_MASK_CTRL;
			if (wr_to(`VFC_OFF_SLICE))     slice_r     <= reg_wdata;
			if (wr_to(`VFC_OFF_SEP))       sep_thr_r   <= reg_wdata;
			if (wr_to(`VFC_OFF_LEAD))      lead_r      <= reg_wdata;
			if (wr_to(`VFC_OFF_TRAIL))     trail_r     <= reg_wdata;
			if (wr_to(`VFC_OFF_FMT))       fmt_r       <= reg_wdata;
			if (wr_to(`VFC_OFF_TSTA))      tsta_r      <= reg_wdata;
			if (wr_to(`VFC_OFF_TSTB))      tstb_r      <= reg_wdata & `VFC_MASK_TSTB;
		end
	end
	// Writing the high byte alone must not disturb a running divider
	always_ff @(posedge sys_clk) begin
		if (rst) div_r <= {`VFC_RST_DIV_HI, 4'(`VFC_RST_DIV_LO >> 4)};
		else if (wr_to(`VFC_OFF_DIV_LO))
			div_r <= {div_hi_r, reg_wdata[7:4]};
	end

	// Reads only sample state, so polling status is harmless
	always_ff @(posedge sys_clk) begin
		if (rst) rdata_r <= '0;
		else if (reg_rd) begin
			case (reg_addr)
				`VFC_OFF_DIV_HI:    rdata_r <= div_hi_r;
				`VFC_OFF_DIV_LO:    rdata_r <= div_lo_r;
				`VFC_OFF_CLAMP_POS: rdata_r <= clamp_pos_r;
				`VFC_OFF_CLAMP_LEN: rdata_r <= clamp_len_r;
				`VFC_OFF_CTRL:      rdata_r <= ctrl_r;
				`VFC_OFF_SLICE:     rdata_r <= slice_r;
				`VFC_OFF_SEP:       rdata_r <= sep_thr_r;
				`VFC_OFF_LEAD:      rdata_r <= lead_r;
				`VFC_OFF_TRAIL:     rdata_r <= trail_r;
				`VFC_OFF_STAT:      rdata_r <= stat_r;
				`VFC_OFF_FMT:       rdata_r <= fmt_r;
				`VFC_OFF_TSTA:      rdata_r <= tsta_r;
				`VFC_OFF_TSTB:      rdata_r <= tstb_r;
				`VFC_OFF_TRDA:      rdata_r <= lines_r[7:0];
				`VFC_OFF_TRDB:      rdata_r <= sep_cnt_r;
				default:            rdata_r <= '0;
			endcase
		end
	end

	// One monitor per sync input: line, green, frame, hold
	assign mon_in = {hold_pin, frame_sync_pin, sog_sync, line_sync_pin};
	for (genvar i = 0; i < 4; i++) begin : g_mon
		vfc_sync_mon #(
			.TIMEOUT (DETECT_CYCLES),
			.CNT_W   (16)
		) u_mon (
			.sys_clk       (sys_clk),
			.rst           (rst),
			.sig           (mon_in[i]),
			.present_r     (mon_present[i]),
			.active_high_r (mon_high[i])
		);
	end

	// Inputs folded to active high
	assign line_norm  = line_sync_pin ~^ mon_high[0];
	assign sog_norm   = sog_sync ~^ mon_high[1];
	assign frame_norm = frame_sync_pin ~^ mon_high[2];
	// Pin sync wins when both line syncs are present
	assign active_line_sync_flag  = ~mon_present[0] & mon_present[1];
	assign active_frame_sync_flag = ~mon_present[2];
	assign hold_pol     = ctrl_r[`VFC_B_HOLD_OVR] ? ctrl_r[`VFC_B_HOLD_HIGH] : mon_high[3];
	assign hold_pin_act = hold_pin ~^ hold_pol;

	always_ff @(posedge sys_clk) begin
		if (rst) stat_r <= '0;
		else stat_r <= {mon_present[0], active_line_sync_flag, mon_high[0],
			           mon_present[2], active_frame_sync_flag,
			           ~active_frame_sync_flag & ~mon_high[2],
			           mon_present[1], mon_high[3]};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sel_line_r    <= 1'b0;
			sel_line_d_r  <= 1'b0;
			frame_sel_r   <= 1'b0;
			frame_sel_d_r <= 1'b0;
		end else begin
			sel_line_r    <= active_line_sync_flag ? sog_norm : line_norm;
			sel_line_d_r  <= sel_line_r;
			frame_sel_r   <= active_frame_sync_flag ? sep_state_r : frame_norm;
			frame_sel_d_r <= frame_sel_r;
		end
	end

	assign line_lead   = sel_line_r & ~sel_line_d_r;
	assign line_trail  = ~sel_line_r & sel_line_d_r;
	assign frame_start = frame_sel_r & ~frame_sel_d_r;

	// 5 MHz separator tick from the system clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tick_r     <= '0;
			sep_tick_r <= 1'b0;
		end else if (tick_r == SEP_LAST) begin
			tick_r     <= '0;
			sep_tick_r <= 1'b1;
		end else begin
			tick_r     <= tick_r + 1'b1;
			sep_tick_r <= 1'b0;
		end
	end

	// Broad pulses of composite sync outlast the count and flip the output
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sep_cnt_r   <= '0;
			sep_state_r <= 1'b0;
		end else if (sog_norm == sep_state_r) sep_cnt_r <= '0;
		else if (sep_cnt_r >= sep_thr_r) begin
			sep_state_r <= sog_norm;
			sep_cnt_r   <= '0;
		end else if (sep_tick_r) sep_cnt_r <= sep_cnt_r + 1'b1;
	end
	// Lead is predicted from the length of the previous frame
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lines_r       <= '0;
			frame_lines_r <= '0;
		end else if (frame_start) begin
			frame_lines_r <= lines_r;
			lines_r       <= '0;
		end else if (line_lead && lines_r != '1)
			lines_r <= lines_r + 1'b1;
	end

	assign lead_hit = (lead_r != '0) && (frame_lines_r != '0) &&
	                  (({1'b0, lines_r} + (LINE_W + 1)'(lead_r)) >= {1'b0, frame_lines_r});
	always_ff @(posedge sys_clk) begin
		if (rst) trail_cnt_r <= '0;
		else if (frame_sel_r) trail_cnt_r <= trail_r;
		else if (line_lead && trail_cnt_r != '0) trail_cnt_r <= trail_cnt_r - 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst) pll_hold_r <= 1'b0;
		else if (ctrl_r[`VFC_B_HOLD_FRAME])
			pll_hold_r <= frame_sel_r | lead_hit | (trail_cnt_r != '0);
		else pll_hold_r <= hold_pin_act;
	end

	// Clamp pulse: external pin or placement/duration after line trailing edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cl_st_r  <= CL_IDLE;
			cl_cnt_r <= '0;
			clamp_r  <= 1'b0;
		end else if (ctrl_r[`VFC_B_CLAMP_EXT]) begin
			cl_st_r <= CL_IDLE;
			clamp_r <= black_hold_pin ^ ctrl_r[`VFC_B_CLAMP_LOW];
		end else begin
			unique case (cl_st_r)
				CL_IDLE: begin
					clamp_r <= 1'b0;
					if (line_trail) begin
						cl_st_r  <= CL_WAIT;
						cl_cnt_r <= clamp_pos_r;
					end
				end
				CL_WAIT: begin
					if (cl_cnt_r <= 8'h01) begin
						cl_st_r  <= CL_ON;
						cl_cnt_r <= clamp_len_r;
						clamp_r  <= 1'b1;
					end else
						cl_cnt_r <= cl_cnt_r - 1'b1;
				end
				CL_ON: begin
					if (cl_cnt_r <= 8'h01) begin
						cl_st_r <= CL_IDLE;
						clamp_r <= 1'b0;
					end else
						cl_cnt_r <= cl_cnt_r - 1'b1;
				end
			endcase
		end
	end

	// Outputs, all taken from flip-flops
	assign reg_rdata        = rdata_r;
	assign clamp_pulse      = clamp_r;
	assign pll_hold         = pll_hold_r;
	assign sep_frame_sync   = sep_state_r;
	assign pll_divide_ratio = div_r;
	assign power_down_n     = ctrl_r[`VFC_B_PWR_N];
	assign seek_low_power   = ctrl_r[`VFC_B_SEEK];
	assign red_clamp_mid    = slice_r[`VFC_B_RED_MID];
	assign blue_clamp_mid   = slice_r[`VFC_B_BLUE_MID];
	assign slicer_level     = slice_r[7:3];
	assign dual_channel     = fmt_r[`VFC_B_DUAL];
	assign parallel_mode    = fmt_r[`VFC_B_PARALLEL];
	assign first_on_b       = fmt_r[`VFC_B_FIRST_B];
	assign fmt_422          = fmt_r[`VFC_B_F422];
	assign input_channel    = fmt_r[`VFC_B_MUX];
	assign bandwidth_sel    = fmt_r[2:1];
	assign ext_clock_sel    = fmt_r[`VFC_B_EXT_CLK];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	ext_clamp_a: assert property (
		ctrl_r[7] |=> clamp_r == ($past(black_hold_pin) ^ $past(ctrl_r[6])))
		else $error("external clamp not followed");
	clamp_start_a: assert property (
		$rose(clamp_r) && !$past(ctrl_r[7]) |-> $past(cl_st_r) == CL_WAIT && cl_cnt_r == $past(clamp_len_r))
		else $error("internal clamp started out of placement");
	pin_hold_a: assert property (
		!ctrl_r[5] |=> pll_hold_r == $past(hold_pin_act))
		else $error("hold not taken from pin");
	frame_hold_a: assert property (
		ctrl_r[5] && (lead_hit || trail_cnt_r != 8'h00 || frame_sel_r) |=> pll_hold_r)
		else $error("frame hold window dropped");
	trail_load_a: assert property (
		$fell(frame_sel_r) |-> trail_cnt_r == $past(trail_r))
		else $error("trail count not loaded");
	ctrl_wr_a: assert property (
		wr_to(`VFC_OFF_CTRL) |=> seek_low_power == $past(reg_wdata[2]) && power_down_n == $past(reg_wdata[1]))
		else $error("control write not applied");
	sep_toggle_a: assert property (
		$changed(sep_state_r) |-> $past(sep_cnt_r) >= $past(sep_thr_r))
		else $error("separator toggled early");
	stat_track_a: assert property (
		!$past(rst) |-> stat_r[7] == $past(mon_present[0]) && stat_r[3] == $past(active_frame_sync_flag))
		else $error("status does not track sync");
	fmt_wr_a: assert property (
		wr_to(`VFC_OFF_FMT) |=> fmt_r == $past(reg_wdata))
		else $error("format write lost");
	div_hold_a: assert property (
		!wr_to(`VFC_OFF_DIV_LO) |=> $stable(div_r))
		else $error("divider changed without low write");
	div_load_a: assert property (
		wr_to(`VFC_OFF_DIV_LO) |=> div_r == {$past(div_hi_r), $past(reg_wdata[7:4])})
		else $error("divider load wrong");
	ro_write_a: assert property (
		reg_wr && (reg_addr == `VFC_OFF_STAT || reg_addr >= `VFC_OFF_TRDA) |=> $stable(ctrl_r) && $stable(fmt_r))
		else $error("read-only write had effect");
	ext_clamp_c: cover property (ctrl_r[7] ##1 $rose(clamp_r));
	int_clamp_c: cover property (!ctrl_r[7] && line_trail ##[1:300] $fell(clamp_r));
	sep_flip_c: cover property ($rose(sep_state_r));
	frame_hold_c: cover property (ctrl_r[5] && $fell(frame_sel_r) ##1 pll_hold_r);
endmodule
`default_nettype wire

// ==== hw/vfc_defines.svh ====
// Offsets, field positions, reset values and timing counts of the front-end bank
// Included by the register bank design file only; no logic lives here
`ifndef VFC_DEFINES_SVH
`define VFC_DEFINES_SVH

// Register offsets
`define VFC_OFF_DIV_HI     8'h01
`define VFC_OFF_DIV_LO     8'h02
`define VFC_OFF_CLAMP_POS  8'h05
`define VFC_OFF_CLAMP_LEN  8'h06
`define VFC_OFF_CTRL       8'h0f
`define VFC_OFF_SLICE      8'h10
`define VFC_OFF_SEP        8'h11
`define VFC_OFF_LEAD       8'h12
`define VFC_OFF_TRAIL      8'h13
`define VFC_OFF_STAT       8'h14
`define VFC_OFF_FMT        8'h15
`define VFC_OFF_TSTA       8'h16
`define VFC_OFF_TSTB       8'h17
`define VFC_OFF_TRDA       8'h18
`define VFC_OFF_TRDB       8'h19

// Reset values and writable masks
`define VFC_RST_DIV_HI     8'h69
`define VFC_RST_DIV_LO     8'hd0
`define VFC_RST_CLAMP_POS  8'h08
`define VFC_RST_CLAMP_LEN  8'h14
`define VFC_RST_CTRL       8'h4e
`define VFC_RST_SLICE      8'h78
`define VFC_RST_SEP        8'h20
`define VFC_RST_LEAD       8'h00
`define VFC_RST_TRAIL      8'h00
`define VFC_RST_FMT        8'hc6
`define VFC_RST_TSTA       8'hff
`define VFC_RST_TSTB       8'h00
`define VFC_MASK_CTRL      8'hfe
`define VFC_MASK_DIV_LO    8'hf0
`define VFC_MASK_TSTB      8'hf8

// Control and slicer register fields
`define VFC_B_CLAMP_EXT    7
`define VFC_B_CLAMP_LOW    6
`define VFC_B_HOLD_FRAME   5
`define VFC_B_HOLD_OVR     4
`define VFC_B_HOLD_HIGH    3
`define VFC_B_SEEK         2
`define VFC_B_PWR_N        1
`define VFC_B_RED_MID      2
`define VFC_B_BLUE_MID     1

// Output format fields
`define VFC_B_DUAL         7
`define VFC_B_PARALLEL     6
`define VFC_B_FIRST_B      5
`define VFC_B_F422         4
`define VFC_B_MUX          3
`define VFC_B_EXT_CLK      0

// Timing
`define VFC_SYS_CLK_KHZ    250000
`define VFC_SEP_CLK_KHZ    5000
`define VFC_SEP_DIV        (`VFC_SYS_CLK_KHZ / `VFC_SEP_CLK_KHZ)
`define VFC_DETECT_US      100
`define VFC_DETECT_CYCLES  (`VFC_DETECT_US * `VFC_SYS_CLK_KHZ / 1000)

`endif

// ==== hw/vfc_pkg.sv ====
// Types shared by the front-end control bank
// Constants live in vfc_defines.svh
package vfc_pkg;
	typedef logic [7:0] vfc_byte_t;
	typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} vfc_clamp_st_t;
endpackage

// ==== hw/vfc_sync_mon.sv ====
// Activity and polarity monitor for one sync input
// Assumes the input is already synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module vfc_sync_mon #(
	parameter int TIMEOUT = 25000,
	parameter int CNT_W   = 16
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Monitored input
	input  wire logic sig,
	// Results
	output var  logic present_r,
	output var  logic active_high_r
);
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT);

	logic             sig_d_r;
	logic [CNT_W-1:0] idle_r;
	logic [CNT_W-1:0] hi_r;
	logic [CNT_W-1:0] lo_r;

	if (TIMEOUT < 2 || TIMEOUT >= 2 ** CNT_W) begin : g_bad_timeout
		$error("vfc_sync_mon: TIMEOUT does not fit CNT_W");
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			sig_d_r <= 1'b0;
		else
			sig_d_r <= sig;
	end

	// Present while an edge was seen within TIMEOUT cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			idle_r    <= LIMIT;
			present_r <= 1'b0;
		end else begin
			if (sig != sig_d_r)
				idle_r <= '0;
			else if (idle_r != LIMIT)
				idle_r <= idle_r + 1'b1;
			present_r <= (idle_r != LIMIT);
		end
	end

	// The pulse is the shorter phase; judged at each rising edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hi_r          <= '0;
			lo_r          <= '0;
			active_high_r <= 1'b1;
		end else begin
			if (sig && !sig_d_r) begin
				active_high_r <= (hi_r < lo_r);
				hi_r          <= '0;
			end else if (sig && hi_r != '1)
				hi_r <= hi_r + 1'b1;
			if (!sig && sig_d_r)
				lo_r <= '0;
			else if (!sig && lo_r != '1)
				lo_r <= lo_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== test/vfc_sync_src.sv ====
// Sync source model: active-high line pulses, one-line frame pulse per frame
// Assumes run is driven from the bench clock domain; both outputs idle low
`timescale 1ns/100ps
`default_nettype none
module vfc_sync_src #(
	parameter int LINE_LEN  = 40,
	parameter int PULSE_LEN = 4,
	parameter int LINES     = 8
) (
	// Clock and control
	input  wire logic sys_clk,
	input  wire logic run,
	// Sync outputs
	output var  logic line_sync,
	output var  logic frame_sync
);
	int pos = 0;
	int line = 0;

	initial begin
		line_sync = 1'b0;
		frame_sync = 1'b0;
	end

	// Pulse far narrower than the separator count the host programs
	always @(posedge sys_clk) begin
		if (!run) begin
			pos <= 0;
			line <= 0;
			line_sync <= 1'b0;
			frame_sync <= 1'b0;
		end else begin
			pos <= (pos == LINE_LEN - 1) ? 0 : pos + 1;
			if (pos == LINE_LEN - 1)
				line <= (line == LINES - 1) ? 0 : line + 1;
			line_sync <= (pos < PULSE_LEN);
			frame_sync <= (line == 0);
		end
	end
endmodule
`default_nettype wire

// ==== test/video_frontend_control_status_regs_test.sv ====
// Self-checking bench for the front-end control bank
// Assumes vfc_regs as top, fed by the sync source model
`timescale 1ns/100ps
`default_nettype none
module video_frontend_control_status_regs_test;
	import vfc_pkg::*;
	localparam vfc_byte_t ra[13] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h11, 8'h12,
		8'h13, 8'h15, 8'h16, 8'h17, 8'h20};
	localparam vfc_byte_t rv[13] = '{8'h69, 8'hd0, 8'h08, 8'h14, 8'h4e, 8'h78, 8'h20, 8'h00,
		8'h00, 8'hc6, 8'hff, 8'h00, 8'h00};
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	vfc_byte_t   reg_addr = 8'h00;
	vfc_byte_t   reg_wdata = 8'h00;
	vfc_byte_t   reg_rdata;
	logic        black_hold_pin = 1'b0;
	logic        hold_pin = 1'b0;
	logic        run = 1'b0;
	logic        line_sync_pin;
	logic        frame_sync_pin;
	logic        clamp_pulse;
	logic        pll_hold;
	logic        sep_o;
	logic        power_down_n;
	logic        seek_low_power;
	logic [11:0] ratio;
	logic [6:0]  sl_o;
	vfc_byte_t   fmt_o;
	vfc_byte_t   exp_q[$];
	vfc_byte_t   msk_q[$];
	vfc_byte_t   m;
	int          err_total = 0;
	int          compares = 0;
	logic        rd_d = 1'b0;
	logic        clamp_on = 1'b0;
	logic        ls_d = 1'b0;
	logic        cp_d = 1'b0;
	int          gap = 0;
	int          wid = 0;

	vfc_regs #(.DETECT_CYCLES(400)) uut (
		.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.line_sync_pin(line_sync_pin), .sog_sync(1'b0), .frame_sync_pin(frame_sync_pin),
		.black_hold_pin(black_hold_pin), .hold_pin(hold_pin), .clamp_pulse(clamp_pulse),
		.pll_hold(pll_hold), .sep_frame_sync(sep_o), .pll_divide_ratio(ratio),
		.power_down_n(power_down_n), .seek_low_power(seek_low_power),
		.red_clamp_mid(sl_o[1]), .blue_clamp_mid(sl_o[0]), .slicer_level(sl_o[6:2]),
		.dual_channel(fmt_o[7]), .parallel_mode(fmt_o[6]), .first_on_b(fmt_o[5]),
		.fmt_422(fmt_o[4]), .input_channel(fmt_o[3]), .bandwidth_sel(fmt_o[2:1]),
		.ext_clock_sel(fmt_o[0])
	);

	vfc_sync_src src (
		.sys_clk(sys_clk), .run(run), .line_sync(line_sync_pin), .frame_sync(frame_sync_pin)
	);

	task automatic chk(input vfc_byte_t got, input vfc_byte_t exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input vfc_byte_t a, input vfc_byte_t d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Expectation queued before the strobe; the watcher pops it
	task automatic rd(input vfc_byte_t a, input vfc_byte_t e, input vfc_byte_t mk);
		exp_q.push_back(e);
		msk_q.push_back(mk);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	always @(posedge sys_clk) begin
		if (rd_d) begin
			m = msk_q.pop_front();
			chk(reg_rdata & m, exp_q.pop_front() & m);
		end
		rd_d <= reg_rd;
	end

	// Placement 3 and duration 5 programmed below
	always @(posedge sys_clk) begin
		gap <= (ls_d && !line_sync_pin) ? 0 : gap + 1;
		wid <= clamp_pulse ? wid + 1 : 0;
		if (clamp_on && clamp_pulse && !cp_d)
			chk(8'(gap), 8'h04);
		if (clamp_on && !clamp_pulse && cp_d)
			chk(8'(wid), 8'h05);
		ls_d <= line_sync_pin;
		cp_d <= clamp_pulse;
	end

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		finish_test();
	end

	initial begin
		vfc_byte_t d;
		void'($urandom(48));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		tick(1);
		chk(fmt_o, 8'hc6);
		chk(ratio[11:4], 8'h69);
		chk({ratio[3:0], 4'h0}, 8'hd0);
		wr(8'h20, 8'h5a);
		for (int i = 0; i < 13; i++)
			rd(ra[i], rv[i], 8'hff);
		wr(8'h16, 8'hfe);
		for (int k = 0; k < 6; k++) begin
			d = vfc_byte_t'($urandom);
			wr(8'h0f, d);
			wr(8'h10, d | 8'h01);
			wr(8'h15, d);
			tick(2);
			chk({6'h0, seek_low_power, power_down_n}, {6'h0, d[2:1]});
			chk({1'b0, sl_o}, {1'b0, d[7:1]});
			chk(fmt_o, d);
			rd(8'h0f, d, 8'hfe);
		end
		// High byte alone must not disturb the divider
		wr(8'h01, 8'h12);
		tick(2);
		chk(ratio[11:4], 8'h69);
		wr(8'h02, 8'h3c);
		tick(2);
		chk(ratio[11:4], 8'h12);
		chk({ratio[3:0], 4'h0}, 8'h30);
		rd(8'h02, 8'h30, 8'hff);
		for (int p = 0; p < 4; p++) begin
			wr(8'h0f, {1'b1, p[0], 2'b01, p[0], 3'b010});
			@(posedge sys_clk);
			black_hold_pin <= p[1];
			hold_pin <= p[1];
			tick(2);
			chk({7'h0, clamp_pulse}, {7'h0, p[1] ^ p[0]});
			chk({7'h0, pll_hold}, {7'h0, p[1] ~^ p[0]});
		end
		wr(8'h0f, 8'h4e);
		wr(8'h05, 8'h03);
		wr(8'h06, 8'h05);
		wr(8'h11, 8'h08);
		run <= 1'b1;
		// Arm between pulses so no clamp is seen half-way
		@(posedge line_sync_pin);
		clamp_on = 1'b1;
		repeat (1200) @(posedge sys_clk);
		rd(8'h14, 8'hb0, 8'hfe);
		// Frame-driven hold: high inside the frame pulse, gone one line after it
		wr(8'h13, 8'h02);
		wr(8'h0f, 8'h6e);
		@(posedge frame_sync_pin);
		tick(20);
		chk({7'h0, pll_hold}, 8'h01);
		tick(160);
		chk({7'h0, pll_hold}, 8'h00);
		// No broad pulse on the idle green input, so the separator never flips
		chk({7'h0, sep_o}, 8'h00);
		tick(3);
		finish_test();
	end
endmodule
`default_nettype wire
